// *** shared/evsum_pkg.sv ***
package evsum_pkg;

  // =====================================================
  // widths and register selection
  localparam int EV_W = 8;
  localparam int GROUPS = 4;
  localparam logic [1:0] GRP0 = 2'h0;
  localparam logic [1:0] GRP1 = 2'h1;
  localparam logic [1:0] GRP2 = 2'h2;
  localparam logic [1:0] GRP3 = 2'h3;
  localparam logic [7:0] EV_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] SRE_RESET = 8'h00;

  // =====================================================
  // group 0 field positions
  localparam int G0_ACCURACY_NOT_ASSURED = 7;
  localparam int G0_APPLIED_VOLTAGE_FAULT = 6;
  localparam int G0_CURRENT_DETECT_FAULT = 5;
  localparam int G0_FIRST_OVER_RANGE = 4;
  localparam int G0_FIRST_UNDER_RANGE = 3;
  localparam int G0_CAPTURE_DONE = 2;
  localparam int G0_MEASUREMENT_DONE = 1;
  localparam int G0_CORRECTION_DONE = 0;

  // =====================================================
  // group 1 field positions
  localparam int G1_FIRST_HIGH = 0;
  localparam int G1_FIRST_WITHIN = 1;
  localparam int G1_FIRST_LOW = 2;
  localparam int G1_SECOND_HIGH = 3;
  localparam int G1_SECOND_INSIDE = 4;
  localparam int G1_SECOND_LOW = 5;
  localparam int G1_BOTH_PASS = 6;
  localparam int G1_LEVEL_FAULT = 7;

  // =====================================================
  // group 3 field positions (bits 0..4 are classes 9..13)
  localparam int G3_LOW_CAP_REJECT = 5;
  localparam int G3_OUT_OF_CLASS = 6;
  localparam int G3_SECOND_OUTSIDE = 7;

  // =====================================================
  // status byte positions
  localparam int STB_MASTER_SUMMARY = 6;

  // =====================================================
  // carriers
  typedef struct packed {
    logic accuracy_not_assured;
    logic applied_voltage_fault;
    logic current_detect_fault;
    logic first_param_over_range;
    logic first_param_under_range;
    logic capture_done;
    logic measurement_done;
    logic correction_measure_done;
  } evsum_meas_ev_t;

  typedef struct packed {
    logic level_fault;
    logic second_param_low;
    logic second_param_inside;
    logic second_param_high;
    logic first_param_low;
    logic first_param_within;
    logic first_param_high;
  } evsum_cmp_ev_t;

  typedef struct packed {
    logic second_param_outside;
    logic out_of_class;
    logic low_capacitance_reject;
    logic [12:0] sort_class;
  } evsum_sort_ev_t;

  typedef struct packed {
    logic read_req;
    logic [1:0] read_sel;
    logic mask_read_req;
    logic mask_write;
    logic [1:0] mask_sel;
    logic [7:0] mask_data;
    logic sre_write;
    logic [7:0] sre_data;
    logic clear_status;
    logic serial_poll;
  } evsum_cmd_t;

endpackage

// *** rtl/evsum_event_status_summary.sv ***
`timescale 1ns/1ps

module evsum_event_status_summary (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // event sources, one-cycle or level conditions
  input wire evsum_pkg::evsum_meas_ev_t meas_ev,
  input wire evsum_pkg::evsum_cmp_ev_t cmp_ev,
  input wire evsum_pkg::evsum_sort_ev_t sort_ev,
  // controller commands
  input wire evsum_pkg::evsum_cmd_t cmd,
  // answers
  output logic [7:0] read_data,
  output logic read_valid,
  output logic [7:0] status_summary_byte,
  output logic service_request
);

  // =====================================================
  // set vectors per group
  logic [7:0] set0;
  logic [7:0] set1;
  logic [7:0] set2;
  logic [7:0] set3;
  logic [7:0] ev_r [evsum_pkg::GROUPS];
  logic [7:0] mask_r [evsum_pkg::GROUPS];
  logic [7:0] sre_r;
  logic [7:0] stb_low;
  logic [7:0] stb_low_r;
  logic [3:0] summary;
  logic rise;
  logic master_summary;
  logic srq_r;

  function automatic logic any_enabled(input logic [7:0] ev,
                                       input logic [7:0] m);
    any_enabled = |(ev & m);
  endfunction

  always_comb begin
    set0 = '0;
    set0[evsum_pkg::G0_ACCURACY_NOT_ASSURED] =
      meas_ev.accuracy_not_assured;
    set0[evsum_pkg::G0_APPLIED_VOLTAGE_FAULT] =
      meas_ev.applied_voltage_fault;
    set0[evsum_pkg::G0_CURRENT_DETECT_FAULT] =
      meas_ev.current_detect_fault;
    set0[evsum_pkg::G0_FIRST_OVER_RANGE] =
      meas_ev.first_param_over_range;
    set0[evsum_pkg::G0_FIRST_UNDER_RANGE] =
      meas_ev.first_param_under_range;
    set0[evsum_pkg::G0_CAPTURE_DONE] = meas_ev.capture_done;
    set0[evsum_pkg::G0_MEASUREMENT_DONE] = meas_ev.measurement_done;
    set0[evsum_pkg::G0_CORRECTION_DONE] =
      meas_ev.correction_measure_done;
  end

  always_comb begin
    set1 = '0;
    set1[evsum_pkg::G1_FIRST_HIGH] = cmp_ev.first_param_high;
    set1[evsum_pkg::G1_FIRST_WITHIN] = cmp_ev.first_param_within;
    set1[evsum_pkg::G1_FIRST_LOW] = cmp_ev.first_param_low;
    set1[evsum_pkg::G1_SECOND_HIGH] = cmp_ev.second_param_high;
    set1[evsum_pkg::G1_SECOND_INSIDE] = cmp_ev.second_param_inside;
    set1[evsum_pkg::G1_SECOND_LOW] = cmp_ev.second_param_low;
    // pass flag follows the two results reported in the same cycle
    set1[evsum_pkg::G1_BOTH_PASS] =
      cmp_ev.first_param_within & cmp_ev.second_param_inside;
    set1[evsum_pkg::G1_LEVEL_FAULT] = cmp_ev.level_fault;
  end

  always_comb begin
    set2 = sort_ev.sort_class[7:0];
    set3 = '0;
    set3[4:0] = sort_ev.sort_class[12:8];
    set3[evsum_pkg::G3_LOW_CAP_REJECT] =
      sort_ev.low_capacitance_reject;
    set3[evsum_pkg::G3_OUT_OF_CLASS] = sort_ev.out_of_class;
    set3[evsum_pkg::G3_SECOND_OUTSIDE] =
      sort_ev.second_param_outside;
  end

  // =====================================================
  // sticky event registers; a set in the clearing cycle survives
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int g = 0; g < evsum_pkg::GROUPS; g++) begin
        ev_r[g] <= evsum_pkg::EV_RESET;
      end
    end else begin
      for (int g = 0; g < evsum_pkg::GROUPS; g++) begin
        logic [7:0] s;
        logic clr;
        unique case (g)
          0: s = set0;
          1: s = set1;
          2: s = set2;
          default: s = set3;
        endcase
        clr = cmd.clear_status
          | (cmd.read_req && cmd.read_sel == 2'(g));
        ev_r[g] <= (clr ? evsum_pkg::EV_RESET : ev_r[g]) | s;
      end
    end
  end

  // =====================================================
  // masks; untouched by event clears
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int g = 0; g < evsum_pkg::GROUPS; g++) begin
        mask_r[g] <= evsum_pkg::MASK_RESET;
      end
      sre_r <= evsum_pkg::SRE_RESET;
    end else begin
      if (cmd.mask_write) begin
        mask_r[cmd.mask_sel] <= cmd.mask_data;
      end
      if (cmd.sre_write) begin
        sre_r <= cmd.sre_data;
      end
    end
  end

  // =====================================================
  // read port: data registered, valid one cycle after request
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      read_data <= 8'h00;
      read_valid <= 1'b0;
    end else begin
      read_valid <= cmd.read_req | cmd.mask_read_req;
      if (cmd.read_req) begin
        read_data <= ev_r[cmd.read_sel];
      end else if (cmd.mask_read_req) begin
        read_data <= mask_r[cmd.mask_sel];
      end
    end
  end

  // =====================================================
  // summaries and service request
  always_comb begin
    for (int g = 0; g < evsum_pkg::GROUPS; g++) begin
      summary[g] = any_enabled(ev_r[g], mask_r[g]);
    end
    stb_low = {4'h0, summary};
    // master summary is a plain OR so it drops when events clear or a mask or sre write disables them
    master_summary = any_enabled(stb_low, sre_r);
    rise = |(stb_low & ~stb_low_r & sre_r);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stb_low_r <= 8'h00;
      srq_r <= 1'b0;
    end else begin
      stb_low_r <= stb_low;
      if (rise) begin
        srq_r <= 1'b1;
      end else if (cmd.serial_poll) begin
        srq_r <= 1'b0;
      end
    end
  end

  // serial poll reads the request bit in bit 6, else master summary
  always_comb begin
    status_summary_byte = stb_low;
    status_summary_byte[evsum_pkg::STB_MASTER_SUMMARY] =
      cmd.serial_poll ? srq_r : master_summary;
  end

  assign service_request = srq_r;

endmodule

// *** testbench/evsum_sva.sv ***
`timescale 1ns/1ps
// ======================================
// port checker for the event summary block
module evsum_sva (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // event sources and commands
  input wire evsum_pkg::evsum_meas_ev_t meas_ev,
  input wire evsum_pkg::evsum_cmp_ev_t cmp_ev,
  input wire evsum_pkg::evsum_sort_ev_t sort_ev,
  input wire evsum_pkg::evsum_cmd_t cmd,
  // answers
  input wire logic [7:0] read_data,
  input wire logic read_valid,
  input wire logic [7:0] status_summary_byte,
  input wire logic service_request
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic quiet;
  assign quiet = {meas_ev, cmp_ev, sort_ev} == 31'h0;
  sequence rd_grp0;
    cmd.read_req && cmd.read_sel == 2'h0 && quiet && !cmd.clear_status;
  endsequence
  a_read_answer: assert property (
    (cmd.read_req || cmd.mask_read_req) |=> read_valid)
    else $error("read request got no answer");
  a_no_stray_valid: assert property (
    !(cmd.read_req || cmd.mask_read_req) |=> !read_valid)
    else $error("read answer without request");
  a_read_clears: assert property (
    rd_grp0 ##1 rd_grp0 |=> read_data == 8'h00)
    else $error("read did not clear the register");
  a_clear_all: assert property (
    cmd.clear_status && quiet |=> status_summary_byte[3:0] == 4'h0)
    else $error("clear status left a summary set");
  a_spare_zero: assert property (
    status_summary_byte[7] == 1'b0 && status_summary_byte[5:4] == 2'h0)
    else $error("unused status bits set");
  a_summary_sticky: assert property (
    status_summary_byte[0] && !cmd.clear_status && !cmd.read_req
    && !cmd.mask_write |=> status_summary_byte[0])
    else $error("summary dropped without a clear");
  a_request_cause: assert property (
    $rose(service_request) |-> $past(status_summary_byte[3:0]) != 4'h0)
    else $error("service request without a summary");
  a_poll_clears: assert property (
    cmd.serial_poll && !cmd.sre_write && (status_summary_byte[3:0]
    & ~$past(status_summary_byte[3:0])) == 4'h0 |=> !service_request)
    else $error("serial poll left the request set");
endmodule

// *** testbench/evsum_host.sv ***
`timescale 1ns/1ps
// ======================================
// remote controller: one command word per clock, held until next call
module evsum_host (
  // clock
  input wire logic clk_sys,
  // command word to the device
  output evsum_pkg::evsum_cmd_t cmd
);
  initial cmd = '0;
  task issue(input evsum_pkg::evsum_cmd_t c);
    @(posedge clk_sys);
    cmd <= c;
  endtask
endmodule

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin \
  miscompares++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb_top;
  // ======================================
  // stimulus and model state
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  evsum_pkg::evsum_meas_ev_t meas_ev = '0;
  evsum_pkg::evsum_cmp_ev_t cmp_ev = '0;
  evsum_pkg::evsum_sort_ev_t sort_ev = '0;
  evsum_pkg::evsum_cmd_t cmd;
  logic [7:0] read_data;
  logic [7:0] status_summary_byte;
  logic read_valid;
  logic service_request;
  logic [31:0] seed = 32'h92C8;
  int miscompares = 0;
  int tests_run = 0;
  logic [7:0] ev [4];
  logic [7:0] msk [4];
  logic [7:0] exp_rd = 8'h00;
  logic exp_rv = 1'b0;
  logic [7:0] sre_m = 8'h00;
  logic [3:0] prev_sm = 4'h0;
  logic srq_m = 1'b0;
  always #25 clk_sys = ~clk_sys;
  evsum_event_status_summary dut_u (.clk_sys(clk_sys), .rst(rst),
    .meas_ev(meas_ev), .cmp_ev(cmp_ev), .sort_ev(sort_ev), .cmd(cmd),
    .read_data(read_data), .read_valid(read_valid),
    .status_summary_byte(status_summary_byte),
    .service_request(service_request));
  evsum_host host_u (.clk_sys(clk_sys), .cmd(cmd));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // ======================================
  // reference model, read before the edge's own updates land
  always @(posedge clk_sys) begin
    logic [7:0] s [4];
    logic [3:0] so;
    for (int g = 0; g < 4; g++) so[g] = |(ev[g] & msk[g]);
    // request fires on a 0 to 1 change of an enabled summary bit
    if (|(so & ~prev_sm & sre_m[3:0])) srq_m = 1'b1;
    else if (cmd.serial_poll) srq_m = 1'b0;
    prev_sm = so;
    if (cmd.sre_write) sre_m = cmd.sre_data;
    s[0] = meas_ev;
    s[1] = {cmp_ev[6], cmp_ev[4] & cmp_ev[1], cmp_ev[5:0]};
    s[2] = sort_ev[7:0];
    s[3] = sort_ev[15:8];
    exp_rv = cmd.read_req | cmd.mask_read_req;
    if (cmd.mask_read_req) exp_rd = msk[cmd.mask_sel];
    if (cmd.read_req) exp_rd = ev[cmd.read_sel];
    if (cmd.read_req) ev[cmd.read_sel] = 8'h00;
    if (cmd.mask_write) msk[cmd.mask_sel] = cmd.mask_data;
    for (int g = 0; g < 4; g++) begin
      if (cmd.clear_status) ev[g] = 8'h00;
      ev[g] |= s[g];
      if (rst) ev[g] = 8'h00;
      if (rst) msk[g] = 8'h00;
    end
    if (rst) begin
      exp_rv = 1'b0;
      sre_m = 8'h00;
      prev_sm = 4'h0;
      srq_m = 1'b0;
    end
  end
  always @(negedge clk_sys) begin
    logic [3:0] sm;
    logic [6:0] sb;
    logic b6;
    for (int g = 0; g < 4; g++) sm[g] = |(ev[g] & msk[g]);
    sb = {status_summary_byte[7], status_summary_byte[5:0]};
    // poll shows the request bit, otherwise the master summary
    b6 = cmd.serial_poll ? srq_m : |(sm & sre_m[3:0]);
    if (!rst) begin
      `CHK("read_valid", exp_rv, read_valid)
      if (exp_rv) `CHK("read_data", exp_rd, read_data)
      `CHK("summary", ({3'h0, sm}), sb)
      `CHK("stb_bit6", b6, status_summary_byte[6])
      `CHK("service_request", srq_m, service_request)
    end
  end
  // ======================================
  // sequence: masks open, random traffic with a reset midway, quiet clears
  initial begin
    evsum_pkg::evsum_cmd_t c;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    for (int g = 0; g < 5; g++) begin
      c = '0;
      c.mask_write = g < 4;
      c.mask_sel = g[1:0];
      c.mask_data = 8'hFF;
      c.sre_write = g == 4;
      c.sre_data = 8'h0F;
      host_u.issue(c);
    end
    for (int i = 0; i < 1500; i++) begin
      seed = xs(seed);
      c = '0;
      c.read_req = seed[26] & seed[27];
      c.read_sel = seed[1:0];
      c.mask_write = seed[28] & seed[29] & seed[30];
      c.mask_sel = seed[3:2];
      c.mask_data = seed[15:8] | seed[7:0];
      c.mask_read_req = seed[31] & ~c.mask_write;
      c.clear_status = seed[24] & seed[25] & seed[20];
      c.serial_poll = seed[19] & seed[18];
      c.sre_write = seed[21] & seed[22] & seed[23] & seed[17];
      c.sre_data = seed[11:4];
      host_u.issue(c);
      seed = xs(seed);
      {meas_ev, cmp_ev, sort_ev} <= seed[30:0] & seed[31:1];
      rst <= i == 700 || i == 701;
    end
    c = '0;
    c.clear_status = 1'b1;
    host_u.issue(c);
    {meas_ev, cmp_ev, sort_ev} <= '0;
    c = '0;
    c.read_req = 1'b1;
    repeat (2) host_u.issue(c);
    c = '0;
    repeat (3) host_u.issue(c);
    tally_and_finish;
  end
  // hang guard: a run is about 1520 cycles, this allows well over double
  initial begin
    repeat (4000) @(posedge clk_sys);
    miscompares++;
    tally_and_finish;
  end
  task tally_and_finish;
    if (miscompares == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
endmodule
bind evsum_event_status_summary evsum_sva chk_u (.clk_sys(clk_sys),
  .rst(rst), .meas_ev(meas_ev), .cmp_ev(cmp_ev), .sort_ev(sort_ev),
  .cmd(cmd), .read_data(read_data), .read_valid(read_valid),
  .status_summary_byte(status_summary_byte),
  .service_request(service_request));
